// ==== hdl/dshs_defs_defs.svh ====
`ifndef DSHS_DEFS_DEFS_SVH
`define DSHS_DEFS_DEFS_SVH

// ****************************************************************
// Clock and filter timing
// ****************************************************************
`define DSHS_CLK_PERIOD_PS 25000
`define DSHS_BRK_FILTER_NS 20000
`define DSHS_AUX_CLEAR_NS 3500
// Cycles that a level must persist to last strictly longer than ns
`define DSHS_NS_GT_CYC(ns) \
	((((ns) * 1000) + `DSHS_CLK_PERIOD_PS - 1) / `DSHS_CLK_PERIOD_PS + 1)

// ****************************************************************
// Synchronised input vector field positions
// ****************************************************************
`define DSHS_IN_CARD 0
`define DSHS_IN_MREQ 1
`define DSHS_IN_MRST 2
`define DSHS_IN_AREQ 3
`define DSHS_IN_ARST 4
`define DSHS_IN_FORCE 5
`define DSHS_IN_UVH 6
`define DSHS_IN_UVL 7
`define DSHS_IN_UVA 8
`define DSHS_IN_OCH 9
`define DSHS_IN_OCL 10
`define DSHS_IN_OCA 11
`define DSHS_IN_TEMP 12
`define DSHS_IN_PGH 13
`define DSHS_IN_PGL 14
`define DSHS_IN_PGA 15
`define DSHS_IN_W 16

// ****************************************************************
// Reset values
// ****************************************************************
`define DSHS_RST_OFF 1'b0
`define DSHS_RST_DISCH 1'b1
`define DSHS_RST_FLAG_N 1'b1

`endif

// ==== hdl/dshs_pkg.sv ====
package dshs_pkg;

	// Gate drive mode of one external main switch
	typedef enum logic [1:0]
	{
		DSHS_GATE_CHARGE = 2'b00,
		DSHS_GATE_WEAK = 2'b01,
		DSHS_GATE_STRONG = 2'b10
	} dshs_gate_mode_t;

endpackage : dshs_pkg

// ==== hdl/dshs_persist_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

// Qualifies a level once it has stayed high for more than LIMIT cycles
module dshs_persist_timer
	import dshs_pkg::*;
#(
	parameter int LIMIT = 801
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level to qualify
	input wire logic level,
	// Qualified level
	output logic qualified
);

	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] CNT_MAX = CW'(LIMIT);

	logic [CW-1:0] cnt_q, cnt_d;
	logic qual_q, qual_d;

	// Any drop of the level restarts the count, so only unbroken runs count
	always_comb
	begin
		cnt_d = cnt_q;
		qual_d = 1'b0;
		if (!level)
			cnt_d = '0;
		else if (cnt_q != CNT_MAX)
			cnt_d = cnt_q + CW'(1);
		if (level && (cnt_q == CNT_MAX))
			qual_d = 1'b1;
	end

	// Count and output registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_q <= '0;
			qual_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			qual_q <= qual_d;
		end
	end

	assign qualified = qual_q;

endmodule : dshs_persist_timer

`default_nettype wire

// ==== hdl/dshs_slot_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dshs_defs_defs.svh"

module dshs_slot_ctrl
	import dshs_pkg::*;
#(
	parameter int NUM_SLOTS = 2,
	parameter int BRK_FILTER_CYCLES = `DSHS_NS_GT_CYC(`DSHS_BRK_FILTER_NS),
	parameter int AUX_CLEAR_CYCLES = `DSHS_NS_GT_CYC(`DSHS_AUX_CLEAR_NS)
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Device supply lockout comparator
	input wire logic deviceSupplyLow,
	// Slot presence and commands
	input wire logic [NUM_SLOTS-1:0] cardAbsent,
	input wire logic [NUM_SLOTS-1:0] mainPowerRequest,
	input wire logic [NUM_SLOTS-1:0] mainRequestReset,
	input wire logic [NUM_SLOTS-1:0] auxPowerRequest,
	input wire logic [NUM_SLOTS-1:0] auxRequestReset,
	input wire logic [NUM_SLOTS-1:0] forceAllSwitches,
	// Input supply undervoltage comparators
	input wire logic [NUM_SLOTS-1:0] highRailInputLow,
	input wire logic [NUM_SLOTS-1:0] lowRailInputLow,
	input wire logic [NUM_SLOTS-1:0] standbyRailInputLow,
	// Breaker and temperature comparators
	input wire logic [NUM_SLOTS-1:0] highRailOverCurrent,
	input wire logic [NUM_SLOTS-1:0] lowRailOverCurrent,
	input wire logic [NUM_SLOTS-1:0] standbyRailOverCurrent,
	input wire logic [NUM_SLOTS-1:0] overTemp,
	// Output good comparators
	input wire logic [NUM_SLOTS-1:0] highRailOutputGood,
	input wire logic [NUM_SLOTS-1:0] lowRailOutputGood,
	input wire logic [NUM_SLOTS-1:0] standbyRailOutputGood,
	// Switch enables
	output logic [NUM_SLOTS-1:0] highRailGateDrive,
	output logic [NUM_SLOTS-1:0] lowRailGateDrive,
	output logic [NUM_SLOTS-1:0] standbyRailSwitch,
	// Gate pulldown modes
	output logic [NUM_SLOTS-1:0][1:0] highRailGateMode,
	output logic [NUM_SLOTS-1:0][1:0] lowRailGateMode,
	// Output discharge enables
	output logic [NUM_SLOTS-1:0] highRailDischarge,
	output logic [NUM_SLOTS-1:0] lowRailDischarge,
	output logic [NUM_SLOTS-1:0] standbyRailDischarge,
	// Status flags, active low
	output logic [NUM_SLOTS-1:0] mainTripFlag_n,
	output logic [NUM_SLOTS-1:0] auxTripFlag_n,
	output logic [NUM_SLOTS-1:0] mainSupplyOk_n,
	output logic [NUM_SLOTS-1:0] auxSupplyOk_n
);

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Gate mode decode shared by both main rails
	function automatic dshs_gate_mode_t gateMode(input logic on,
		input logic tripped);
		if (on)
			return DSHS_GATE_CHARGE;
		if (tripped)
			return DSHS_GATE_STRONG;
		return DSHS_GATE_WEAK;
	endfunction : gateMode

	// ****************************************************************
	// Device supply lockout synchroniser
	// ****************************************************************
	logic devMeta_q, devMeta_d, devLow_q, devLow_d;

	// Second flop alone reads the first
	always_comb
	begin
		devMeta_d = deviceSupplyLow;
		devLow_d = devMeta_q;
	end

	// Lockout is assumed active while in reset
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			devMeta_q <= 1'b1;
			devLow_q <= 1'b1;
		end
		else
		begin
			devMeta_q <= devMeta_d;
			devLow_q <= devLow_d;
		end
	end

	// ****************************************************************
	// Per slot control
	// ****************************************************************
	genvar s;
	generate
		for (s = 0; s < NUM_SLOTS; s = s + 1)
		begin : g_slot
			logic [`DSHS_IN_W-1:0] raw, meta_q, meta_d, in_q, in_d;
			logic mainArm_q, mainArm_d, auxArm_q, auxArm_d;
			logic mainFault_q, mainFault_d, aux_trip_flag_n_q, aux_trip_flag_n_d;
			logic mReqPrev_q, mReqPrev_d, aReqPrev_q, aReqPrev_d;
			logic hGate_q, hGate_d, aSw_q, aSw_d;
			logic [1:0] hMode_q, hMode_d;
			logic hDis_q, hDis_d, aDis_q, aDis_d;
			logic mFlag_q, mFlag_d, aFlag_q, aFlag_d;
			logic mOk_q, mOk_d, aOk_q, aOk_d;
			logic ocHighQual, ocLowQual, ocAuxQual, auxClearQual;
			logic forceOn, mainTrip, auxTrip, mainSw, auxSw;

			// Gather the pins of this slot into one vector
			always_comb
			begin
				raw = '0;
				raw[`DSHS_IN_CARD] = cardAbsent[s];
				raw[`DSHS_IN_MREQ] = mainPowerRequest[s];
				raw[`DSHS_IN_MRST] = mainRequestReset[s];
				raw[`DSHS_IN_AREQ] = auxPowerRequest[s];
				raw[`DSHS_IN_ARST] = auxRequestReset[s];
				raw[`DSHS_IN_FORCE] = forceAllSwitches[s];
				raw[`DSHS_IN_UVH] = highRailInputLow[s];
				raw[`DSHS_IN_UVL] = lowRailInputLow[s];
				raw[`DSHS_IN_UVA] = standbyRailInputLow[s];
				raw[`DSHS_IN_OCH] = highRailOverCurrent[s];
				raw[`DSHS_IN_OCL] = lowRailOverCurrent[s];
				raw[`DSHS_IN_OCA] = standbyRailOverCurrent[s];
				raw[`DSHS_IN_TEMP] = overTemp[s];
				raw[`DSHS_IN_PGH] = highRailOutputGood[s];
				raw[`DSHS_IN_PGL] = lowRailOutputGood[s];
				raw[`DSHS_IN_PGA] = standbyRailOutputGood[s];
				meta_d = raw;
				in_d = meta_q;
			end

			// Two flop synchroniser for every pin of the slot
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					meta_q <= '0;
					in_q <= '0;
				end
				else
				begin
					meta_q <= meta_d;
					in_q <= in_d;
				end
			end

			assign forceOn = in_q[`DSHS_IN_FORCE];

			// Breaker filters only run while the rail is really protected
			dshs_persist_timer #(.LIMIT(BRK_FILTER_CYCLES)) u_ocHigh
			(
				.clk(clk),
				.rst(rst),
				.level(in_q[`DSHS_IN_OCH] && hGate_q && !forceOn),
				.qualified(ocHighQual)
			);
			dshs_persist_timer #(.LIMIT(BRK_FILTER_CYCLES)) u_ocLow
			(
				.clk(clk),
				.rst(rst),
				.level(in_q[`DSHS_IN_OCL] && hGate_q && !forceOn),
				.qualified(ocLowQual)
			);
			dshs_persist_timer #(.LIMIT(BRK_FILTER_CYCLES)) u_ocAux
			(
				.clk(clk),
				.rst(rst),
				.level(in_q[`DSHS_IN_OCA] && aSw_q && !forceOn),
				.qualified(ocAuxQual)
			);
			// Aux fault clear needs an unbroken high on the aux reset input
			dshs_persist_timer #(.LIMIT(AUX_CLEAR_CYCLES)) u_auxClear
			(
				.clk(clk),
				.rst(rst),
				.level(in_q[`DSHS_IN_ARST]),
				.qualified(auxClearQual)
			);

			// Arming, fault latches and registered outputs
			always_comb
			begin
				mReqPrev_d = in_q[`DSHS_IN_MREQ];
				aReqPrev_d = in_q[`DSHS_IN_AREQ];
				mainTrip = ocHighQual || ocLowQual;
				auxTrip = ocAuxQual || in_q[`DSHS_IN_TEMP];
				// Main arming follows request edges, a trip disarms
				mainArm_d = mainArm_q;
				if (in_q[`DSHS_IN_MREQ] && !mReqPrev_q)
					mainArm_d = 1'b1;
				if (!in_q[`DSHS_IN_MREQ] && mReqPrev_q)
					mainArm_d = 1'b0;
				if (mainTrip)
					mainArm_d = 1'b0;
				// A hot die refuses the rising edge, so a cycle is needed
				auxArm_d = auxArm_q;
				if (in_q[`DSHS_IN_AREQ] && !aReqPrev_q
					&& !in_q[`DSHS_IN_TEMP])
					auxArm_d = 1'b1;
				if (!in_q[`DSHS_IN_AREQ] && aReqPrev_q)
					auxArm_d = 1'b0;
				if (auxTrip)
					auxArm_d = 1'b0;
				// Set wins over clear on both latches
				mainFault_d = mainFault_q;
				if (mainTrip)
					mainFault_d = 1'b1;
				else if (in_q[`DSHS_IN_MRST])
					mainFault_d = 1'b0;
				aux_trip_flag_n_d = aux_trip_flag_n_q;
				if (auxTrip)
					aux_trip_flag_n_d = 1'b1;
				else if (auxClearQual)
					aux_trip_flag_n_d = 1'b0;
				// Main path ignores aux faults and the reverse
				mainSw = mainArm_q && !in_q[`DSHS_IN_CARD]
					&& !in_q[`DSHS_IN_UVH]
					&& !in_q[`DSHS_IN_UVL]
					&& !mainFault_q && !mainTrip;
				auxSw = auxArm_q && !in_q[`DSHS_IN_CARD]
					&& !in_q[`DSHS_IN_UVA]
					&& !aux_trip_flag_n_q && !auxTrip;
				if (forceOn)
				begin
					mainSw = 1'b1;
					auxSw = 1'b1;
				end
				hGate_d = mainSw;
				aSw_d = auxSw;
				hMode_d = gateMode(mainSw, mainFault_d);
				hDis_d = !mainSw;
				aDis_d = !auxSw;
				mFlag_d = !mainFault_d;
				aFlag_d = !aux_trip_flag_n_d;
				if (forceOn && in_q[`DSHS_IN_CARD])
					aFlag_d = auxSw;
				mOk_d = !(mainSw && in_q[`DSHS_IN_PGH]
					&& in_q[`DSHS_IN_PGL]
					&& !in_q[`DSHS_IN_CARD] && in_q[`DSHS_IN_MREQ]
					&& !in_q[`DSHS_IN_UVH] && !in_q[`DSHS_IN_UVL]
					&& !devLow_q);
				aOk_d = !(auxSw && in_q[`DSHS_IN_PGA]
					&& !in_q[`DSHS_IN_CARD] && !in_q[`DSHS_IN_TEMP]
					&& in_q[`DSHS_IN_AREQ] && !in_q[`DSHS_IN_UVA]
					&& !devLow_q);
				// Reset and lockout beat everything, force included;
				// a request held through lockout counts as a new edge
				if (rst || devLow_q)
				begin
					mainArm_d = `DSHS_RST_OFF;
					auxArm_d = `DSHS_RST_OFF;
					mainFault_d = `DSHS_RST_OFF;
					aux_trip_flag_n_d = `DSHS_RST_OFF;
					mReqPrev_d = `DSHS_RST_OFF;
					aReqPrev_d = `DSHS_RST_OFF;
					hGate_d = `DSHS_RST_OFF;
					aSw_d = `DSHS_RST_OFF;
					hMode_d = DSHS_GATE_WEAK;
					hDis_d = `DSHS_RST_DISCH;
					aDis_d = `DSHS_RST_DISCH;
					mFlag_d = `DSHS_RST_FLAG_N;
					aFlag_d = `DSHS_RST_FLAG_N;
					mOk_d = `DSHS_RST_FLAG_N;
					aOk_d = `DSHS_RST_FLAG_N;
				end
			end

			// Registers only; reset is folded into the next values
			always_ff @(posedge clk)
			begin
				mainArm_q <= mainArm_d;
				auxArm_q <= auxArm_d;
				mainFault_q <= mainFault_d;
				aux_trip_flag_n_q <= aux_trip_flag_n_d;
				mReqPrev_q <= mReqPrev_d;
				aReqPrev_q <= aReqPrev_d;
				hGate_q <= hGate_d;
				aSw_q <= aSw_d;
				hMode_q <= hMode_d;
				hDis_q <= hDis_d;
				aDis_q <= aDis_d;
				mFlag_q <= mFlag_d;
				aFlag_q <= aFlag_d;
				mOk_q <= mOk_d;
				aOk_q <= aOk_d;
			end

			// Outputs from flops; both main rails share one register set
			assign highRailGateDrive[s] = hGate_q;
			assign lowRailGateDrive[s] = hGate_q;
			assign standbyRailSwitch[s] = aSw_q;
			assign highRailGateMode[s] = hMode_q;
			assign lowRailGateMode[s] = hMode_q;
			assign highRailDischarge[s] = hDis_q;
			assign lowRailDischarge[s] = hDis_q;
			assign standbyRailDischarge[s] = aDis_q;
			assign mainTripFlag_n[s] = mFlag_q;
			assign auxTripFlag_n[s] = aFlag_q;
			assign mainSupplyOk_n[s] = mOk_q;
			assign auxSupplyOk_n[s] = aOk_q;
		end
	endgenerate

endmodule : dshs_slot_ctrl

`default_nettype wire

// ==== verification/dshs_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Slot 0 checks
// ****************
module dshs_checker
	import dshs_pkg::*;
#(
	parameter int NUM_SLOTS = 2
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched inputs
	input wire logic deviceSupplyLow,
	input wire logic [NUM_SLOTS-1:0] cardAbsent,
	input wire logic [NUM_SLOTS-1:0] forceAllSwitches,
	input wire logic [NUM_SLOTS-1:0] standbyRailInputLow,
	input wire logic [NUM_SLOTS-1:0] highRailOutputGood,
	input wire logic [NUM_SLOTS-1:0] standbyRailOutputGood,
	// Watched outputs
	input wire logic [NUM_SLOTS-1:0] highRailGateDrive,
	input wire logic [NUM_SLOTS-1:0] lowRailGateDrive,
	input wire logic [NUM_SLOTS-1:0] standbyRailSwitch,
	input wire logic [NUM_SLOTS-1:0][1:0] highRailGateMode,
	input wire logic [NUM_SLOTS-1:0] highRailDischarge,
	input wire logic [NUM_SLOTS-1:0] mainTripFlag_n,
	input wire logic [NUM_SLOTS-1:0] mainSupplyOk_n,
	input wire logic [NUM_SLOTS-1:0] auxSupplyOk_n
);
	// One domain; slot input levels get four cycles, the lockout three, to pass the synchroniser
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_disch;
		highRailDischarge[0] == !highRailGateDrive[0];
	endproperty
	a_disch: assert property (p_disch) else $error("discharge wrong");
	property p_lock;
		deviceSupplyLow [*3] |=> !highRailGateDrive[0] && !standbyRailSwitch[0];
	endproperty
	a_lock: assert property (p_lock) else $error("lockout ignored");
	property p_pgm;
		(!highRailOutputGood[0]) [*4] |=> mainSupplyOk_n[0];
	endproperty
	a_pgm: assert property (p_pgm) else $error("main good early");
	property p_pga;
		(!standbyRailOutputGood[0]) [*4] |=> auxSupplyOk_n[0];
	endproperty
	a_pga: assert property (p_pga) else $error("aux good early");
	property p_card;
		(cardAbsent[0] && !forceAllSwitches[0]) [*4] |=>
			!highRailGateDrive[0] && !standbyRailSwitch[0] && mainSupplyOk_n[0];
	endproperty
	a_card: assert property (p_card) else $error("slot on, no card");
	property p_force;
		(forceAllSwitches[0] && !deviceSupplyLow) [*4] |=> highRailGateDrive[0]
			&& lowRailGateDrive[0] && standbyRailSwitch[0];
	endproperty
	a_force: assert property (p_force) else $error("force ignored");
	property p_weak;
		!highRailGateDrive[0] && mainTripFlag_n[0] |->
			highRailGateMode[0] == DSHS_GATE_WEAK;
	endproperty
	a_weak: assert property (p_weak) else $error("not weak pulldown");
	property p_strong;
		!highRailGateDrive[0] && !mainTripFlag_n[0] |->
			highRailGateMode[0] == DSHS_GATE_STRONG;
	endproperty
	a_strong: assert property (p_strong) else $error("not strong");
	property p_trip;
		$fell(mainTripFlag_n[0]) |-> !lowRailGateDrive[0]
			&& $stable(standbyRailSwitch[0]);
	endproperty
	a_trip: assert property (p_trip) else $error("trip effect wrong");
	property p_auxuv;
		(standbyRailInputLow[0] && !forceAllSwitches[0]) [*4] |=>
			!standbyRailSwitch[0];
	endproperty
	a_auxuv: assert property (p_auxuv) else $error("aux on in uv");
endmodule : dshs_checker
`default_nettype wire

// ==== verification/dshs_rail_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Slot switches and loads
// ****************
module dshs_rail_model
(
	// Clock
	input wire logic clk,
	// Switch enables
	input wire logic [1:0] highRailGateDrive,
	input wire logic [1:0] lowRailGateDrive,
	input wire logic [1:0] standbyRailSwitch,
	// Shorted load on slot 0: high, low, standby
	input wire logic [2:0] shortLoad,
	// Comparator results
	output logic [1:0] highRailOutputGood,
	output logic [1:0] lowRailOutputGood,
	output logic [1:0] standbyRailOutputGood,
	output logic [1:0] highRailOverCurrent,
	output logic [1:0] lowRailOverCurrent,
	output logic [1:0] standbyRailOverCurrent
);
	// Outputs ramp one cycle late; a short holds them low
	always_ff @(posedge clk)
	begin
		highRailOutputGood <= highRailGateDrive & ~{1'b0, shortLoad[0]};
		lowRailOutputGood <= lowRailGateDrive & ~{1'b0, shortLoad[1]};
		standbyRailOutputGood <= standbyRailSwitch & ~{1'b0, shortLoad[2]};
	end
	// A short only draws current through a closed switch
	assign highRailOverCurrent = highRailGateDrive & {1'b0, shortLoad[0]};
	assign lowRailOverCurrent = lowRailGateDrive & {1'b0, shortLoad[1]};
	assign standbyRailOverCurrent = standbyRailSwitch & {1'b0, shortLoad[2]};
endmodule : dshs_rail_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Testbench
// ****************
module tb_top
	import dshs_pkg::*;
;
	// Stimulus
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic deviceSupplyLow = 1'b0;
	logic [1:0] cardAbsent = 2'h0, mainPowerRequest = 2'h0;
	logic [1:0] mainRequestReset = 2'h0, auxPowerRequest = 2'h0;
	logic [1:0] auxRequestReset = 2'h0, forceAllSwitches = 2'h0;
	logic [1:0] highRailInputLow = 2'h0, lowRailInputLow = 2'h0;
	logic [1:0] standbyRailInputLow = 2'h0, overTemp = 2'h0;
	logic [2:0] shortLoad = 3'h0;
	// Model and design outputs
	logic [1:0] highRailOutputGood, lowRailOutputGood, standbyRailOutputGood;
	logic [1:0] highRailOverCurrent, lowRailOverCurrent, standbyRailOverCurrent;
	logic [1:0] highRailGateDrive, lowRailGateDrive, standbyRailSwitch;
	logic [1:0][1:0] highRailGateMode, lowRailGateMode;
	logic [1:0] highRailDischarge, lowRailDischarge, standbyRailDischarge;
	logic [1:0] mainTripFlag_n, auxTripFlag_n, mainSupplyOk_n, auxSupplyOk_n;
	int error_cnt = 0;
	int n_checks = 0;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// Short filters keep the run brief
	dshs_slot_ctrl #(.BRK_FILTER_CYCLES(8), .AUX_CLEAR_CYCLES(4))
		dshs_slot_ctrl_inst (.clk, .rst, .deviceSupplyLow, .cardAbsent,
		.mainPowerRequest, .mainRequestReset, .auxPowerRequest,
		.auxRequestReset, .forceAllSwitches, .highRailInputLow,
		.lowRailInputLow, .standbyRailInputLow, .highRailOverCurrent,
		.lowRailOverCurrent, .standbyRailOverCurrent, .overTemp,
		.highRailOutputGood, .lowRailOutputGood, .standbyRailOutputGood,
		.highRailGateDrive, .lowRailGateDrive, .standbyRailSwitch,
		.highRailGateMode, .lowRailGateMode, .highRailDischarge,
		.lowRailDischarge, .standbyRailDischarge, .mainTripFlag_n,
		.auxTripFlag_n, .mainSupplyOk_n, .auxSupplyOk_n);
	dshs_rail_model dshs_rail_model_inst (.clk, .highRailGateDrive,
		.lowRailGateDrive, .standbyRailSwitch, .shortLoad,
		.highRailOutputGood, .lowRailOutputGood, .standbyRailOutputGood,
		.highRailOverCurrent, .lowRailOverCurrent, .standbyRailOverCurrent);
	// Compare and count
	task automatic chk(input string nm, input logic [1:0] got,
		input logic [1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	// Inputs move only at falling edges
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// Reset state
	task automatic t_reset();
		chk("gates", highRailGateDrive | lowRailGateDrive, 2'h0);
		chk("mode", highRailGateMode[0], DSHS_GATE_WEAK);
		chk("disch", standbyRailDischarge, 2'h3);
		chk("flags", {mainTripFlag_n[0], auxTripFlag_n[0]}, 2'h3);
		$display("test reset done");
	endtask : t_reset
	// Request edges and supply undervoltage
	task automatic t_main();
		mainPowerRequest[0] = 1'b1;
		cyc(10);
		chk("on", {highRailGateDrive[0], lowRailGateDrive[0]}, 2'h3);
		chk("disch", lowRailDischarge[0], 1'b0);
		chk("pg", mainSupplyOk_n[0], 1'b0);
		highRailInputLow[0] = 1'b1;
		cyc(5);
		chk("uvh", {highRailGateDrive[0], lowRailGateDrive[0]}, 2'h0);
		chk("pg", mainSupplyOk_n[0], 1'b1);
		highRailInputLow[0] = 1'b0;
		lowRailInputLow[0] = 1'b1;
		cyc(5);
		chk("uvl", {highRailGateDrive[0], lowRailGateDrive[0]}, 2'h0);
		lowRailInputLow[0] = 1'b0;
		cyc(5);
		mainPowerRequest[0] = 1'b0;
		cyc(5);
		chk("off", {highRailGateDrive[0], lowRailGateDrive[0]}, 2'h0);
		chk("mode", lowRailGateMode[0], DSHS_GATE_WEAK);
		$display("test main done");
	endtask : t_main
	// Breaker filter, trip and recovery
	task automatic t_trip();
		mainPowerRequest[0] = 1'b1;
		auxPowerRequest[0] = 1'b1;
		cyc(10);
		shortLoad = 3'h2;
		cyc(5);
		shortLoad = 3'h0;
		cyc(5);
		chk("glitch", {mainTripFlag_n[0], lowRailGateDrive[0]}, 2'h3);
		shortLoad = 3'h1;
		cyc(16);
		shortLoad = 3'h0;
		chk("trip", {mainTripFlag_n[0], highRailGateDrive[0]}, 2'h0);
		chk("strong", lowRailGateMode[0], DSHS_GATE_STRONG);
		chk("aux", standbyRailSwitch[0], 1'b1);
		mainPowerRequest[0] = 1'b0;
		mainRequestReset[0] = 1'b1;
		cyc(5);
		chk("clear", mainTripFlag_n[0], 1'b1);
		mainRequestReset[0] = 1'b0;
		$display("test trip done");
	endtask : t_trip
	// Aux breaker, clear time and thermal restart
	task automatic t_aux();
		chk("aux", {standbyRailDischarge[0], auxSupplyOk_n[0]}, 2'h0);
		shortLoad = 3'h4;
		cyc(16);
		shortLoad = 3'h0;
		chk("trip", {standbyRailSwitch[0], auxTripFlag_n[0]}, 2'h0);
		auxPowerRequest[0] = 1'b0;
		auxRequestReset[0] = 1'b1;
		cyc(2);
		auxRequestReset[0] = 1'b0;
		cyc(5);
		chk("short low", auxTripFlag_n[0], 1'b0);
		auxRequestReset[0] = 1'b1;
		cyc(10);
		chk("cleared", auxTripFlag_n[0], 1'b1);
		auxRequestReset[0] = 1'b0;
		auxPowerRequest[0] = 1'b1;
		cyc(8);
		overTemp[0] = 1'b1;
		cyc(4);
		chk("hot", {standbyRailSwitch[0], auxTripFlag_n[0]}, 2'h0);
		chk("pg", auxSupplyOk_n[0], 1'b1);
		auxPowerRequest[0] = 1'b0;
		cyc(3);
		auxPowerRequest[0] = 1'b1;
		cyc(5);
		overTemp[0] = 1'b0;
		cyc(5);
		chk("no cycle", standbyRailSwitch[0], 1'b0);
		auxPowerRequest[0] = 1'b0;
		auxRequestReset[0] = 1'b1;
		cyc(10);
		auxRequestReset[0] = 1'b0;
		auxPowerRequest[0] = 1'b1;
		cyc(6);
		chk("restart", standbyRailSwitch[0], 1'b1);
		standbyRailInputLow[0] = 1'b1;
		cyc(5);
		chk("uva", standbyRailSwitch[0], 1'b0);
		standbyRailInputLow[0] = 1'b0;
		$display("test aux done");
	endtask : t_aux
	// Card absent, force and lockout
	task automatic t_force();
		cardAbsent[0] = 1'b1;
		mainPowerRequest[0] = 1'b1;
		cyc(6);
		chk("card", {highRailGateDrive[0], standbyRailSwitch[0]}, 2'h0);
		chk("pg", {mainSupplyOk_n[0], auxSupplyOk_n[0]}, 2'h3);
		forceAllSwitches[0] = 1'b1;
		highRailInputLow[0] = 1'b1;
		overTemp[0] = 1'b1;
		cyc(6);
		chk("force", {lowRailGateDrive[0], standbyRailSwitch[0]}, 2'h3);
		chk("status", auxTripFlag_n[0], 1'b1);
		deviceSupplyLow = 1'b1;
		cyc(5);
		chk("uvlo", {highRailGateDrive[0], standbyRailSwitch[0]}, 2'h0);
		$display("test force done");
	endtask : t_force
	// Main sequence
	initial
	begin
		cyc(6);
		rst = 1'b0;
		cyc(2);
		t_reset();
		t_main();
		t_trip();
		t_aux();
		t_force();
		end_sim();
	end
endmodule : tb_top
bind dshs_slot_ctrl dshs_checker #(.NUM_SLOTS(NUM_SLOTS)) dshs_checker_inst
	(.clk, .rst, .deviceSupplyLow, .cardAbsent, .forceAllSwitches,
	.standbyRailInputLow, .highRailOutputGood, .standbyRailOutputGood,
	.highRailGateDrive, .lowRailGateDrive, .standbyRailSwitch,
	.highRailGateMode, .highRailDischarge, .mainTripFlag_n, .mainSupplyOk_n,
	.auxSupplyOk_n);
`default_nettype wire
